// ===== verilog/mmut_pkg.sv
/*
  Shared constants and types of the address-translation front end.
  Assumes a 32-bit core address path and a 29-bit physical bus.
*/
package mmut_pkg;

  // Register addresses; entry-high and fault in the control-register region, the other three in the low region
  localparam logic [31:0] MMUT_CTRL_ADDR  = 32'h0FFF_FFE0;
  localparam logic [31:0] MMUT_LOW_ADDR   = 32'h0FFF_FFF4;
  localparam logic [31:0] MMUT_BASE_ADDR  = 32'h0FFF_FFF8;
  localparam logic [31:0] MMUT_HIGH_ADDR  = 32'hFFFF_FF60;
  localparam logic [31:0] MMUT_FAULT_ADDR = 32'hFFFF_FFFC;

  // translation_control fields
  localparam int          MMUT_CTRL_AT    = 0;
  localparam int          MMUT_CTRL_IX    = 1;
  localparam int          MMUT_CTRL_TF    = 2;
  localparam int          MMUT_CTRL_SV    = 8;
  localparam logic [31:0] MMUT_CTRL_WMASK = 32'h0000_0103;
  localparam logic [31:0] MMUT_CTRL_RESET = 32'h0000_0000;

  // page_entry_high fields: page number 31:10, identifier 7:0
  localparam int          MMUT_VPN_LSB    = 10;
  localparam int          MMUT_PROCESS_SPACE_IDENTIFIER_W     = 8;

  // page_entry_low fields
  localparam int          MMUT_PPN_LSB    = 10;
  localparam int          MMUT_LOW_V      = 8;
  localparam int          MMUT_LOW_PR     = 5;
  localparam int          MMUT_LOW_SZ     = 4;
  localparam int          MMUT_LOW_C      = 3;
  localparam int          MMUT_LOW_D      = 2;
  localparam int          MMUT_LOW_SH     = 1;

  // Physical masks for the fixed regions and the shadow
  localparam logic [31:0] MMUT_CACHED_MASK   = 32'h7FFF_FFFF;
  localparam logic [31:0] MMUT_UNCACHED_MASK = 32'h1FFF_FFFF;

  typedef enum logic [2:0] {
    RG_LOW      = 3'h0,
    RG_CACHED   = 3'h4,
    RG_UNCACHED = 3'h5,
    RG_UPPER    = 3'h6,
    RG_CTRL     = 3'h7
  } mmut_region_type;

  typedef struct packed {
    logic [21:0] virtual_page_number;
    logic [7:0]  process_space_identifier;
    logic [18:0] ppn;
    logic        v;
    logic        sz;
    logic        sh;
    logic        c;
    logic        d;
    logic [1:0]  pr;
  } mmut_entry_type;

endpackage : mmut_pkg

// ===== verilog/mmut_tlb_if.sv
/*
  Carrier between the translation control and the entry array.
  Assumes both ends sit on the same core clock.
*/
`timescale 1ns/10ps
interface mmut_tlb_if;
  import mmut_pkg::*;
  logic [31:0]    va;
  logic [7:0]     process_space_identifier;
  logic           ix;
  logic           skip_process_space_identifier;
  logic           hit;
  mmut_entry_type hit_entry;
  logic           load;
  mmut_entry_type load_entry;
  logic           flush;

  modport ctl (output va, process_space_identifier, ix, skip_process_space_identifier, load, load_entry, flush,
               input hit, hit_entry);
  modport arr (input va, process_space_identifier, ix, skip_process_space_identifier, load, load_entry, flush,
               output hit, hit_entry);
endinterface : mmut_tlb_if

// ===== verilog/mmut_region.sv
/*
  Classifies a virtual address into its region.
  Assumes the caller handles user-mode checks itself.
*/
`timescale 1ns/10ps
module mmut_region
  import mmut_pkg::*;
(
  input  wire logic [31:0]     va,
  output mmut_region_type      region
);
  always_comb
  begin
    if (!va[31])
      region = RG_LOW;
    else
      region = mmut_region_type'(va[31:29]);
  end
endmodule : mmut_region

// ===== verilog/mmut_tlb.sv
/*
  Set-associative entry array with combinational lookup.
  Assumes software never makes two ways hit at once.
*/
`timescale 1ns/10ps
module mmut_tlb
  import mmut_pkg::*;
#(
  parameter int WAYS = 4,
  parameter int SETS = 32
)
(
  input  wire logic  mclk,
  input  wire logic  nrst,
  mmut_tlb_if.arr    tlb
);
  localparam int IDXW = $clog2(SETS);
  localparam int WAYW = (WAYS > 1) ? $clog2(WAYS) : 1;

  typedef struct packed {
    mmut_entry_type [WAYS*SETS-1:0] ent;
    logic [WAYW-1:0]                victim;
  } mmut_tlb_state_type;

  mmut_tlb_state_type st_reg;
  mmut_tlb_state_type st_next;
  logic [IDXW-1:0]    idx;
  logic [IDXW-1:0]    lidx;
  logic [WAYS-1:0]    match;
  mmut_entry_type     way_ent [WAYS];

  // Optional identifier hash spreads processes over the sets
  assign idx  = tlb.va[12 +: IDXW]
              ^ (tlb.ix ? tlb.process_space_identifier[IDXW-1:0] : '0);
  assign lidx = tlb.load_entry.virtual_page_number[2 +: IDXW]
              ^ (tlb.ix ? tlb.load_entry.process_space_identifier[IDXW-1:0] : '0);

  genvar w;
  generate
    for (w = 0; w < WAYS; w++)
    begin : g_way
      assign way_ent[w] = st_reg.ent[w*SETS + int'(idx)];
      assign match[w] = way_ent[w].v
        && way_ent[w].virtual_page_number[21:2] == tlb.va[31:12]
        && (way_ent[w].sz || way_ent[w].virtual_page_number[1:0] == tlb.va[11:10])
        && (way_ent[w].sh || tlb.skip_process_space_identifier
            || way_ent[w].process_space_identifier == tlb.process_space_identifier);
    end
  endgenerate

  always_comb
  begin
    tlb.hit       = |match;
    tlb.hit_entry = '0;
    for (int i = 0; i < WAYS; i++)
      if (match[i])
        tlb.hit_entry = tlb.hit_entry | way_ent[i];
    st_next = st_reg;
    if (tlb.flush)
      for (int i = 0; i < WAYS*SETS; i++)
        st_next.ent[i].v = 1'b0;
    if (tlb.load)
    begin
      st_next.ent[int'(st_reg.victim)*SETS + int'(lidx)] = tlb.load_entry;
      st_next.victim = WAYW'(st_reg.victim + 1'b1);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
endmodule : mmut_tlb

// ===== verilog/mmut_top.sv
/*
  Translation front end: region decode, entry lookup, bypass, shadow
  masking and the five translation registers on the privileged port.
  Assumes one request per cycle from the core and an external cache
  enable; protection and dirty checks live outside this block.
*/
// Functional notes
// - Fixed regions bypass the entry lookup entirely
// - Cached clears bit 31; uncached clears 31:29
// - Paged regions search entries; hit gives address
// - Paged lookup without match raises miss exception
// - Translation off passes virtual address unchanged
// - Top three physical bits ignored, addresses alias
// - Cache address stored with top three bits zero
// - Control register selects single or multiple space
// - Match page number and identifier of indexed entry
// - Entry-high holds the 8-bit process identifier
// - Reset clears control bits and all other registers
// - Registers reachable only from privileged accesses
// - User access at or above 2 Gbyte is error
// - Exceptions load faulting upper 22 bits into entry-high
// - Load instruction copies entry-high and entry-low
// - Entry-low changes only by software writes
// - Table base is plain software storage
// - Fault register holds address until next exception or software write
`timescale 1ns/10ps
module mmut_top
  import mmut_pkg::*;
#(
  parameter int WAYS = 4,
  parameter int SETS = 32
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        cache_enable,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_vaddr,
  input  wire logic        req_user,
  output logic             resp_valid,
  output logic [31:0]      resp_paddr,
  output logic [31:0]      resp_cache_addr,
  output logic             resp_cacheable,
  output logic             resp_tlb_miss,
  output logic             resp_addr_err,
  input  wire logic        tlb_load_instruction,
  input  wire logic        reg_req,
  input  wire logic        reg_write,
  input  wire logic        reg_user,
  input  wire logic [31:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  output logic             reg_ack,
  output logic             reg_err,
  output logic [31:0]      reg_rdata
);

  typedef struct packed {
    logic [31:0] page_entry_high;
    logic [31:0] page_entry_low;
    logic [31:0] table_base_pointer;
    logic [31:0] fault_virtual_address;
    logic [31:0] translation_control;
    logic        resp_valid;
    logic [31:0] resp_paddr;
    logic [31:0] resp_cache_addr;
    logic        resp_cacheable;
    logic        resp_miss;
    logic        resp_aerr;
    logic        reg_ack;
    logic        reg_err;
    logic [31:0] reg_rdata;
  } mmut_state_type;

  mmut_state_type  st_reg;
  mmut_state_type  st_next;
  mmut_region_type region;
  mmut_tlb_if      tlb ();

  logic        at_on;
  logic        ix_on;
  logic        sv_on;
  logic        aerr;
  logic        fault;
  logic        paged;
  logic        wr_ok;
  logic [31:0] pa;
  logic        pa_cache;
  logic [28:0] page_pa;

  mmut_region u_region
  (
    .va     (req_vaddr),
    .region (region)
  );

  mmut_tlb #(
    .WAYS (WAYS),
    .SETS (SETS)
  ) u_tlb
  (
    .mclk (mclk),
    .nrst (nrst),
    .tlb  (tlb)
  );

  assign at_on = st_reg.translation_control[MMUT_CTRL_AT];
  assign ix_on = st_reg.translation_control[MMUT_CTRL_IX];
  assign sv_on = st_reg.translation_control[MMUT_CTRL_SV];
  assign wr_ok = reg_req && reg_write && !reg_user;

  // Lookup is driven from the live request, identifier from entry-high
  assign tlb.va        = req_vaddr;
  assign tlb.process_space_identifier      = st_reg.page_entry_high[MMUT_PROCESS_SPACE_IDENTIFIER_W-1:0];
  assign tlb.ix        = ix_on;
  // Single space in privileged mode ignores the identifier
  assign tlb.skip_process_space_identifier = sv_on && !req_user;
  assign tlb.load      = tlb_load_instruction;
  assign tlb.flush     = wr_ok && reg_addr == MMUT_CTRL_ADDR
                      && reg_wdata[MMUT_CTRL_TF];

  // Entry image assembled from the two staging registers
  always_comb
  begin
    tlb.load_entry      = '0;
    tlb.load_entry.virtual_page_number  = st_reg.page_entry_high[31:MMUT_VPN_LSB];
    tlb.load_entry.process_space_identifier = st_reg.page_entry_high[MMUT_PROCESS_SPACE_IDENTIFIER_W-1:0];
    tlb.load_entry.ppn  = st_reg.page_entry_low[28:MMUT_PPN_LSB];
    tlb.load_entry.v    = st_reg.page_entry_low[MMUT_LOW_V];
    tlb.load_entry.pr   = st_reg.page_entry_low[MMUT_LOW_PR +: 2];
    tlb.load_entry.sz   = st_reg.page_entry_low[MMUT_LOW_SZ];
    tlb.load_entry.c    = st_reg.page_entry_low[MMUT_LOW_C];
    tlb.load_entry.d    = st_reg.page_entry_low[MMUT_LOW_D];
    tlb.load_entry.sh   = st_reg.page_entry_low[MMUT_LOW_SH];
  end

  // Page frame plus offset; 4 kbyte pages keep twelve offset bits
  assign page_pa = tlb.hit_entry.sz
                 ? {tlb.hit_entry.ppn[18:2], req_vaddr[11:0]}
                 : {tlb.hit_entry.ppn, req_vaddr[9:0]};

  assign aerr  = req_user && req_vaddr[31];
  assign paged = at_on && (region == RG_LOW || region == RG_UPPER);
  assign fault = req_valid && (aerr || (paged && !tlb.hit));

  always_comb
  begin
    pa       = req_vaddr;
    pa_cache = 1'b0;
    if (!at_on)
    begin
      pa       = req_vaddr;
      pa_cache = region != RG_UNCACHED && region != RG_CTRL;
    end
    else
    begin
      case (region)
        RG_CACHED:
        begin
          pa       = req_vaddr & MMUT_CACHED_MASK;
          pa_cache = 1'b1;
        end
        RG_UNCACHED:
          pa = req_vaddr & MMUT_UNCACHED_MASK;
        RG_CTRL:
          pa = req_vaddr;
        RG_LOW, RG_UPPER:
        begin
          pa       = {3'h0, page_pa};
          pa_cache = tlb.hit_entry.c;
        end
        default:
          pa = req_vaddr;
      endcase
    end
  end

  always_comb
  begin
    st_next            = st_reg;
    st_next.resp_valid = 1'b0;
    st_next.reg_ack    = 1'b0;
    st_next.reg_err    = 1'b0;

    if (reg_req)
    begin
      st_next.reg_ack   = 1'b1;
      st_next.reg_rdata = '0;
      if (reg_user)
        st_next.reg_err = 1'b1;
      else
      begin
        case (reg_addr)
          MMUT_HIGH_ADDR:
          begin
            st_next.reg_rdata = st_reg.page_entry_high;
            if (reg_write)
              st_next.page_entry_high = reg_wdata;
          end
          MMUT_LOW_ADDR:
          begin
            st_next.reg_rdata = st_reg.page_entry_low;
            if (reg_write)
              st_next.page_entry_low = reg_wdata;
          end
          MMUT_BASE_ADDR:
          begin
            st_next.reg_rdata = st_reg.table_base_pointer;
            if (reg_write)
              st_next.table_base_pointer = reg_wdata;
          end
          MMUT_FAULT_ADDR:
          begin
            st_next.reg_rdata = st_reg.fault_virtual_address;
            if (reg_write)
              st_next.fault_virtual_address = reg_wdata;
          end
          MMUT_CTRL_ADDR:
          begin
            st_next.reg_rdata = st_reg.translation_control;
            if (reg_write)
              st_next.translation_control = reg_wdata & MMUT_CTRL_WMASK;
          end
          default:
            st_next.reg_rdata = '0;
        endcase
      end
    end

    if (req_valid)
    begin
      st_next.resp_valid      = 1'b1;
      st_next.resp_aerr       = aerr;
      st_next.resp_miss       = !aerr && paged && !tlb.hit;
      st_next.resp_paddr      = pa;
      // Shadow bits dropped so aliases share one cache line
      st_next.resp_cache_addr = pa & MMUT_UNCACHED_MASK;
      st_next.resp_cacheable  = cache_enable && pa_cache && !fault;
    end

    // Hardware capture wins over a same-cycle software write
    if (fault)
    begin
      st_next.page_entry_high[31:MMUT_VPN_LSB] =
        req_vaddr[31:MMUT_VPN_LSB];
      st_next.fault_virtual_address = req_vaddr;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_reg                     <= '0;
      st_reg.translation_control <= MMUT_CTRL_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign resp_valid      = st_reg.resp_valid;
  assign resp_paddr      = st_reg.resp_paddr;
  assign resp_cache_addr = st_reg.resp_cache_addr;
  assign resp_cacheable  = st_reg.resp_cacheable;
  assign resp_tlb_miss   = st_reg.resp_miss;
  assign resp_addr_err   = st_reg.resp_aerr;
  assign reg_ack         = st_reg.reg_ack;
  assign reg_err         = st_reg.reg_err;
  assign reg_rdata       = st_reg.reg_rdata;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_fixed_cached: assert property (
    req_valid && at_on && !req_user && req_vaddr[31:29] == 3'h4
    |=> resp_valid && !resp_tlb_miss
        && resp_paddr == ($past(req_vaddr) & 32'h7FFF_FFFF))
    else $error("cached region address not bit-31 cleared");

  a_fixed_uncached: assert property (
    req_valid && at_on && !req_user && req_vaddr[31:29] == 3'h5
    |=> !resp_tlb_miss && !resp_cacheable
        && resp_paddr == {3'h0, $past(req_vaddr[28:0])})
    else $error("uncached region address not masked");

  a_paged_hit: assert property (
    req_valid && paged && !aerr && tlb.hit
    |=> !resp_tlb_miss && resp_paddr[31:29] == 3'h0)
    else $error("paged hit did not translate");

  a_miss_raise: assert property (
    req_valid && paged && !aerr && !tlb.hit
    |=> resp_tlb_miss && !resp_addr_err
        && st_reg.fault_virtual_address == $past(req_vaddr))
    else $error("missing entry did not raise miss");

  a_bypass_pass: assert property (
    req_valid && !at_on && !aerr
    |=> resp_paddr == $past(req_vaddr) && !resp_tlb_miss)
    else $error("bypass altered the address");

  a_shadow_mask: assert property (
    resp_valid |-> resp_cache_addr[31:29] == 3'h0
                   && resp_cache_addr[28:0] == resp_paddr[28:0])
    else $error("cache address keeps shadow bits");

  a_user_high: assert property (
    req_valid && req_user && req_vaddr[31]
    |=> resp_valid && resp_addr_err && !resp_cacheable && !resp_tlb_miss)
    else $error("user high access not rejected");

  a_vpn_capture: assert property (
    fault |=> st_reg.page_entry_high[31:10] == $past(req_vaddr[31:10]))
    else $error("faulting page number not captured");

  a_priv_regs: assert property (
    reg_req && reg_user
    |=> reg_ack && reg_err && reg_rdata == 32'h0000_0000)
    else $error("user register access not refused");

  a_low_stable: assert property (
    !(wr_ok && reg_addr == MMUT_LOW_ADDR)
    |=> $stable(st_reg.page_entry_low))
    else $error("entry-low changed without software write");

  a_base_stable: assert property (
    !(wr_ok && reg_addr == MMUT_BASE_ADDR)
    |=> $stable(st_reg.table_base_pointer))
    else $error("table base changed without software write");

  a_fault_hold: assert property (
    !fault && !(wr_ok && reg_addr == MMUT_FAULT_ADDR)
    |=> $stable(st_reg.fault_virtual_address))
    else $error("fault address changed without cause");

  c_paged_hit: cover property (
    req_valid && paged && tlb.hit ##1 resp_valid);
  c_tlb_miss: cover property (resp_tlb_miss);
  c_user_error: cover property (resp_addr_err);
  c_load_then_hit: cover property (
    tlb_load_instruction ##[1:20] req_valid && paged && tlb.hit);

endmodule : mmut_top

// ===== sim/mmut_core_model.sv
/*
  Behavioural core on the request side: translation requests, register
  accesses and entry loads. Assumes answers come within a few cycles.
*/
`timescale 1ns/10ps
module mmut_core_model
  import mmut_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resp_valid,
  input  wire logic [31:0] resp_paddr,
  input  wire logic [31:0] resp_cache_addr,
  input  wire logic        resp_cacheable,
  input  wire logic        resp_tlb_miss,
  input  wire logic        resp_addr_err,
  input  wire logic        reg_ack,
  input  wire logic        reg_err,
  input  wire logic [31:0] reg_rdata,
  output logic             cache_enable,
  output logic             req_valid,
  output logic [31:0]      req_vaddr,
  output logic             req_user,
  output logic             tlb_load_instruction,
  output logic             reg_req,
  output logic             reg_write,
  output logic             reg_user,
  output logic [31:0]      reg_addr,
  output logic [31:0]      reg_wdata
);
  initial
  begin
    cache_enable = 1'b1;
    req_valid = 1'b0;
    req_vaddr = 32'h0000_0000;
    req_user = 1'b0;
    tlb_load_instruction = 1'b0;
    reg_req = 1'b0;
    reg_write = 1'b0;
    reg_user = 1'b0;
    reg_addr = 32'h0000_0000;
    reg_wdata = 32'h0000_0000;
  end

  task automatic xlate(input logic [31:0] a, input logic u,
                       output logic [31:0] p, c, output logic [3:0] f);
    int i;
    @(negedge mclk);
    req_valid = 1'b1;
    req_vaddr = a;
    req_user = u;
    @(negedge mclk);
    req_valid = 1'b0;
    // Inverted, so a late sample cannot pass by luck
    req_vaddr = ~a;
    for (i = 0; i < 4 && resp_valid !== 1'b1; i++)
      @(negedge mclk);
    p = resp_paddr;
    c = resp_cache_addr;
    f = {resp_valid, resp_tlb_miss, resp_addr_err, resp_cacheable};
  endtask : xlate

  task automatic acc(input logic w, u, input logic [31:0] a, d,
                     output logic [31:0] q, output logic [1:0] e);
    int i;
    @(negedge mclk);
    reg_req = 1'b1;
    reg_write = w;
    reg_user = u;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_req = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    for (i = 0; i < 4 && reg_ack !== 1'b1; i++)
      @(negedge mclk);
    q = reg_rdata;
    e = {reg_ack, reg_err};
  endtask : acc

  // Cache switch moves off the sampling edge like every other input
  task automatic set_cache(input logic on);
    @(negedge mclk);
    cache_enable = on;
  endtask : set_cache

  // Callers only hand page numbers below 2 Gbyte
  task automatic load(input logic [31:0] hi, lo);
    logic [31:0] q;
    logic [1:0]  e;
    acc(1'b1, 1'b0, MMUT_HIGH_ADDR, hi, q, e);
    acc(1'b1, 1'b0, MMUT_LOW_ADDR, lo, q, e);
    @(negedge mclk);
    tlb_load_instruction = 1'b1;
    @(negedge mclk);
    tlb_load_instruction = 1'b0;
  endtask : load
endmodule : mmut_core_model

// ===== sim/mmut_top_test.sv
/*
  Self-checking bench of the translation front end.
  Assumes the core model drives every request input.
*/
`timescale 1ns/10ps
module mmut_top_test;
  import mmut_pkg::*;
  logic        mclk, nrst, cache_enable, req_valid, req_user;
  logic        tlb_load_instruction, reg_req, reg_write, reg_user;
  logic        resp_valid, resp_cacheable, resp_tlb_miss;
  logic        resp_addr_err, reg_ack, reg_err;
  logic [31:0] req_vaddr, reg_addr, reg_wdata, reg_rdata;
  logic [31:0] resp_paddr, resp_cache_addr, q, p, c;
  logic [3:0]  f;
  logic [1:0]  e;
  int          error_cnt, comparisons, cycles;

  mmut_top uut (.mclk, .nrst, .cache_enable, .req_valid, .req_vaddr,
    .req_user, .resp_valid, .resp_paddr, .resp_cache_addr,
    .resp_cacheable, .resp_tlb_miss, .resp_addr_err,
    .tlb_load_instruction, .reg_req, .reg_write, .reg_user, .reg_addr,
    .reg_wdata, .reg_ack, .reg_err, .reg_rdata);

  mmut_core_model core (.mclk, .resp_valid, .resp_paddr,
    .resp_cache_addr, .resp_cacheable, .resp_tlb_miss, .resp_addr_err,
    .reg_ack, .reg_err, .reg_rdata, .cache_enable, .req_valid,
    .req_vaddr, .req_user, .tlb_load_instruction, .reg_req, .reg_write,
    .reg_user, .reg_addr, .reg_wdata);

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic final_report;
    if (error_cnt == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  // Whole run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, x);
    comparisons++;
    if (s !== x)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic rd(input string n, input logic [31:0] a, x);
    core.acc(1'b0, 1'b0, a, 32'h0000_0000, q, e);
    chk(n, q, x);
  endtask : rd

  task automatic wr(input logic [31:0] a, d);
    core.acc(1'b1, 1'b0, a, d, q, e);
  endtask : wr

  task automatic tr(input logic [31:0] a, input logic u,
                    input logic [31:0] xp, input logic [3:0] xf);
    core.xlate(a, u, p, c, f);
    chk("flags", {28'h000_0000, f}, {28'h000_0000, xf});
    if (xp !== 32'hFFFF_FFFF)
      chk("paddr", p, xp);
  endtask : tr

  task automatic t_regs;
    rd("ctrl reset", MMUT_CTRL_ADDR, 32'h0000_0000);
    rd("unmapped", 32'h0FFF_FFE4, 32'h0000_0000);
    chk("ack", {30'h0, e}, 32'h0000_0002);
    wr(MMUT_BASE_ADDR, 32'hA5A5_0F0F);
    rd("base", MMUT_BASE_ADDR, 32'hA5A5_0F0F);
    wr(MMUT_LOW_ADDR, 32'h0000_5118);
    rd("low", MMUT_LOW_ADDR, 32'h0000_5118);
    core.acc(1'b1, 1'b1, MMUT_BASE_ADDR, 32'h0000_0000, q, e);
    chk("user err", {30'h0, e}, 32'h0000_0003);
    rd("base kept", MMUT_BASE_ADDR, 32'hA5A5_0F0F);
    core.acc(1'b0, 1'b1, MMUT_LOW_ADDR, 32'h0000_0000, q, e);
    chk("user rdata", q, 32'h0000_0000);
  endtask : t_regs

  task automatic t_off;
    tr(32'hC000_1234, 1'b0, 32'hC000_1234, 4'h9);
    chk("cache addr", c, 32'h0000_1234);
    tr(32'h8000_0440, 1'b1, 32'hFFFF_FFFF, 4'hA);
    rd("fault", MMUT_FAULT_ADDR, 32'h8000_0440);
    core.acc(1'b0, 1'b0, MMUT_HIGH_ADDR, 32'h0000_0000, q, e);
    chk("high vpn", q & 32'hFFFF_FC00, 32'h8000_0400);
    tr(32'h0000_0100, 1'b1, 32'h0000_0100, 4'h9);
    rd("fault held", MMUT_FAULT_ADDR, 32'h8000_0440);
  endtask : t_off

  task automatic t_on;
    // Control written only from fixed-region code
    wr(MMUT_CTRL_ADDR, 32'h0000_0001);
    tr(32'h8000_1000, 1'b0, 32'h0000_1000, 4'h9);
    tr(32'hA000_1000, 1'b0, 32'h0000_1000, 4'h8);
    tr(32'h0040_2000, 1'b0, 32'hFFFF_FFFF, 4'hC);
    rd("fault miss", MMUT_FAULT_ADDR, 32'h0040_2000);
    core.load(32'h0000_1005, 32'h0000_5118);
    tr(32'h0000_1234, 1'b0, 32'h0000_5234, 4'h9);
    chk("hit cache addr", c, 32'h0000_5234);
    wr(MMUT_HIGH_ADDR, 32'h0000_1006);
    tr(32'h0000_1234, 1'b0, 32'hFFFF_FFFF, 4'hC);
    wr(MMUT_CTRL_ADDR, 32'h0000_0101);
    tr(32'h0000_1234, 1'b0, 32'h0000_5234, 4'h9);
  endtask : t_on

  task automatic t_modes;
    // Cache switched off: hits and fixed regions lose cacheability
    core.set_cache(1'b0);
    tr(32'h8000_1000, 1'b0, 32'h0000_1000, 4'h8);
    tr(32'h0000_1234, 1'b0, 32'h0000_5234, 4'h8);
    core.set_cache(1'b1);
    // Flush bit empties the array and never reads back
    wr(MMUT_CTRL_ADDR, 32'h0000_0105);
    rd("ctrl flush", MMUT_CTRL_ADDR, 32'h0000_0101);
    tr(32'h0000_1234, 1'b0, 32'hFFFF_FFFF, 4'hC);
    // Hashed index: load and lookup must agree on the set
    wr(MMUT_CTRL_ADDR, 32'h0000_0003);
    core.load(32'h0000_1006, 32'h0000_5118);
    tr(32'h0000_1234, 1'b0, 32'h0000_5234, 4'h9);
  endtask : t_modes

  initial
  begin
    nrst = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    t_regs();
    t_off();
    t_on();
    t_modes();
    final_report();
  end
endmodule : mmut_top_test
